// >>> src/tmr_pkg.sv
// Summary of operation
// [RL1] mode 0 normal, 1/5 phase-correct, 2 clear-on-compare, 3/7 fast PWM; 4,6 reserved
// [RL2] compare load immediate in modes 0,2; at TOP in 1,3,5; at BOTTOM in 7
// [RL3] counting depends only on mode; output_action only shapes the waveform outputs
// [RL4] normal mode counts up, wrapping 0xff to 0x00
// [RL5] normal mode sets overflow_flag as count becomes zero; cleared on service
// [RL6] mode 2 clears the count on match with compare_a
// [RL7] mode 2 compare_a unbuffered; a value below count is missed until wrap
// [RL8] mode 2 sets compare_a_flag each time count reaches TOP
// [RL9] mode 2 with action 1 toggles wave_out_a on each match
// [RL10] mode 2 sets overflow_flag when count goes from MAX to 0x00
// [RL11] fast PWM single slope BOTTOM to TOP; TOP 0xff in 3, compare_a in 7
// [RL12] fast PWM increments to TOP then clears next timer cycle
// [RL13] fast PWM action 2 clear on match set at BOTTOM; action 3 opposite
// [RL14] PWM action 1 toggles wave_out_a only with mode bit 2; never for channel b
// [RL15] fast PWM sets overflow_flag each time the counter reaches TOP
// [RL16] fast PWM keeps compare double buffering, also in toggle use
// [RL17] fast PWM compare BOTTOM gives spike; MAX gives constant level
// [RL18] phase-correct counts up to TOP and down to BOTTOM; TOP 0xff or compare_a
// [RL19] phase-correct non-inverting clears on up match, sets on down match
// [RL20] phase-correct holds TOP one timer cycle then reverses
// [RL21] phase-correct sets overflow_flag each time counter reaches BOTTOM
// [RL22] waveform drives the pin only while its direction is output
// [RL23] action 0 leaves output untouched and disconnects it from the pin
// [RL24] count write blocks every compare match in the next timer cycle
// [RL25] counter, matches and flags advance only on count-enable cycles
package tmr_pkg;
   localparam logic [7:0] TMR_MAX = 8'hff;
   localparam logic [7:0] TMR_BOTTOM = 8'h00;
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_FF = 3'h1;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FAST_FF = 3'h3;
   localparam logic [2:0] MODE_PC_A = 3'h5;
   localparam logic [2:0] MODE_FAST_A = 3'h7;
   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h4;
   localparam logic [3:0] ADDR_CMP_A = 4'h8;
   localparam logic [3:0] ADDR_CMP_B = 4'hc;
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   // control and flag field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACT_A_LSB = 4;
   localparam int CTRL_ACT_B_LSB = 6;
   localparam int CTRL_DIR_A_BIT = 8;
   localparam int CTRL_DIR_B_BIT = 9;
   localparam int FLG_OVF_BIT = 0;
   localparam int FLG_CMPA_BIT = 1;
   localparam int FLG_CMPB_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [1:0] act_b;
      logic [1:0] act_a;
      logic [2:0] mode;
      logic dir_b;
      logic dir_a;
   } tmr_ctrl_s;

   typedef struct packed {
      logic a_out;
      logic a_oe;
      logic b_out;
      logic b_oe;
   } tmr_pins_s;
endpackage

// >>> src/tmr_core.sv
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Registers (word address bits [3:2] in avs_address[3:0]):
// 0x0 ctrl: [2:0] mode_select, [5:4] output_action a, [7:6] output_action b,
//     [8] direction a, [9] direction b
// 0x4 count_value, 0x8 compare_a, 0xc compare_b (buffer when double buffered)
// flags at 0x10: bit0 overflow, bit1 compare_a, bit2 compare_b; write 1 clears
module tmr_core
   import tmr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic count_en,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic ovf_service,
   input wire logic ovf_ack,
   output logic cmpa_pending,
   output tmr_pins_s pins
);
   tmr_ctrl_s ctrl;
   logic [7:0] count_value;
   logic [7:0] compare_a;
   logic [7:0] compare_b;
   logic [7:0] buf_a;
   logic [7:0] buf_b;
   logic count_down;
   logic block_next;
   logic overflow_flag;
   logic compare_a_flag;
   logic compare_b_flag;
   logic wave_out_a;
   logic wave_out_b;
   logic rd_done;
   logic [7:0] top;
   logic [7:0] next_count;
   logic next_down;
   logic is_pwm;
   logic is_fast;
   logic is_pc;
   logic ovf_evt;
   logic match_a;
   logic match_b;
   logic at_bottom;
   logic immediate;
   logic load_now;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_flags;
   logic tick;

   function automatic logic sel(input logic [4:0] a, input logic [3:0] off);
      sel = (a[4] == 1'b0) && (a[3:0] == off);
   endfunction

   // reads take two cycles so read data comes from a flop; writes go at once
   // while the clock enable is low nothing can be taken, so every request waits
   assign avs_waitrequest = ~clk_en | (avs_read & ~rd_done);
   assign wr_ctrl = clk_en & avs_write & sel(avs_address, ADDR_CTRL) & avs_byteenable[0];
   assign wr_count = clk_en & avs_write & sel(avs_address, ADDR_COUNT) & avs_byteenable[0];
   assign wr_cmp_a = clk_en & avs_write & sel(avs_address, ADDR_CMP_A) & avs_byteenable[0];
   assign wr_cmp_b = clk_en & avs_write & sel(avs_address, ADDR_CMP_B) & avs_byteenable[0];
   assign wr_flags = clk_en & avs_write & avs_address[4] & avs_byteenable[0];
   assign tick = clk_en & count_en; // [RL25]

   always_comb begin
      is_fast = (ctrl.mode == MODE_FAST_FF) || (ctrl.mode == MODE_FAST_A);
      is_pc = (ctrl.mode == MODE_PC_FF) || (ctrl.mode == MODE_PC_A);
      is_pwm = is_fast | is_pc;
      // [RL1] TOP source by mode
      if (ctrl.mode == MODE_CTC || ctrl.mode == MODE_PC_A || ctrl.mode == MODE_FAST_A) begin
         top = compare_a;
      end else begin
         top = TMR_MAX;
      end
      immediate = (ctrl.mode == MODE_NORMAL) || (ctrl.mode == MODE_CTC) ||
                  (ctrl.mode[2] & ~ctrl.mode[0]); // [RL2]
   end

   // counting sequence, chosen by mode only [RL3]
   always_comb begin
      next_down = count_down;
      next_count = count_value + 8'h01; // [RL4] wraps past 0xff
      ovf_evt = 1'b0;
      load_now = 1'b0;
      if (is_fast) begin
         if (count_value == top) begin
            next_count = TMR_BOTTOM; // [RL11] [RL12]
            ovf_evt = 1'b1; // [RL15]
            load_now = (ctrl.mode == MODE_FAST_FF); // [RL2] load at TOP
         end
         if (ctrl.mode == MODE_FAST_A && count_value == TMR_BOTTOM) begin
            load_now = 1'b1; // [RL2] load at BOTTOM
         end
      end else if (is_pc) begin
         if (count_value == top) begin
            next_down = 1'b1; // [RL20] top held for this one cycle
            next_count = count_value - 8'h01; // [RL18]
            load_now = 1'b1; // [RL2]
         end else if (count_down) begin
            if (count_value == TMR_BOTTOM) begin
               next_down = 1'b0;
               next_count = 8'h01;
            end else begin
               next_count = count_value - 8'h01; // [RL18]
            end
         end
         ovf_evt = count_down && count_value == 8'h01; // [RL21] reaching bottom
      end else if (ctrl.mode == MODE_CTC) begin
         // a match blocked by a count write also skips the clear [RL24]
         if (match_a) begin
            next_count = TMR_BOTTOM; // [RL6] a missed low value runs to wrap [RL7]
         end
         ovf_evt = count_value == TMR_MAX; // [RL10]
      end else begin
         ovf_evt = count_value == TMR_MAX; // [RL5]
      end
   end

   assign at_bottom = count_value == TMR_BOTTOM;
   assign match_a = ~block_next & (count_value == compare_a); // [RL24]
   assign match_b = ~block_next & (count_value == compare_b); // [RL24]

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count_value <= TMR_BOTTOM;
         count_down <= 1'b0;
      end else if (wr_count) begin
         count_value <= avs_writedata[7:0];
      end else if (tick) begin
         count_value <= next_count;
         count_down <= is_pc ? next_down : 1'b0;
      end
   end

   // count write blocks matches of the next timer cycle, even if stopped
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         block_next <= 1'b0;
      end else if (wr_count) begin
         block_next <= 1'b1; // [RL24]
      end else if (tick) begin
         block_next <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl <= tmr_ctrl_s'(CTRL_RESET[8:0]);
      end else if (wr_ctrl) begin
         ctrl.mode <= avs_writedata[CTRL_MODE_LSB +: 3];
         ctrl.act_a <= avs_writedata[CTRL_ACT_A_LSB +: 2];
         ctrl.act_b <= avs_writedata[CTRL_ACT_B_LSB +: 2];
         ctrl.dir_a <= avs_writedata[CTRL_DIR_A_BIT];
         ctrl.dir_b <= avs_writedata[CTRL_DIR_B_BIT];
      end
   end

   // software writes the buffer; compare copies it per mode [RL16]
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         buf_a <= TMR_BOTTOM;
         buf_b <= TMR_BOTTOM;
         compare_a <= TMR_BOTTOM;
         compare_b <= TMR_BOTTOM;
      end else begin
         if (wr_cmp_a) begin
            buf_a <= avs_writedata[7:0];
         end
         if (wr_cmp_b) begin
            buf_b <= avs_writedata[7:0];
         end
         if (immediate) begin
            compare_a <= wr_cmp_a ? avs_writedata[7:0] : buf_a; // [RL2] [RL7]
            compare_b <= wr_cmp_b ? avs_writedata[7:0] : buf_b;
         end else if (tick && load_now) begin
            compare_a <= buf_a; // [RL2]
            compare_b <= buf_b;
         end
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
      end else if (clk_en) begin
         if (tick && ovf_evt) begin
            overflow_flag <= 1'b1; // [RL5] [RL10] [RL15] [RL21]
         end else if (ovf_ack || (wr_flags && avs_writedata[FLG_OVF_BIT])) begin
            overflow_flag <= 1'b0; // [RL5]
         end
         if (tick && match_a) begin
            compare_a_flag <= 1'b1; // [RL8]
         end else if (wr_flags && avs_writedata[FLG_CMPA_BIT]) begin
            compare_a_flag <= 1'b0;
         end
         if (tick && match_b) begin
            compare_b_flag <= 1'b1;
         end else if (wr_flags && avs_writedata[FLG_CMPB_BIT]) begin
            compare_b_flag <= 1'b0;
         end
      end
   end

   // waveform registers; action 0 leaves them alone [RL23] [RL3]
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
      end else if (tick) begin
         if (!is_pwm) begin
            if (match_a) begin
               case (ctrl.act_a)
                  2'h1: wave_out_a <= ~wave_out_a; // [RL9]
                  2'h2: wave_out_a <= 1'b0;
                  2'h3: wave_out_a <= 1'b1;
                  default: wave_out_a <= wave_out_a;
               endcase
            end
            if (match_b) begin
               case (ctrl.act_b)
                  2'h1: wave_out_b <= ~wave_out_b;
                  2'h2: wave_out_b <= 1'b0;
                  2'h3: wave_out_b <= 1'b1;
                  default: wave_out_b <= wave_out_b;
               endcase
            end
         end else if (is_fast) begin
            // with action 2 or 3 a match at TOP is ignored; the BOTTOM action covers it [RL17]
            if (ctrl.act_a[1] && count_value == top) begin
               wave_out_a <= ~ctrl.act_a[0]; // [RL13]
            end else if (ctrl.act_a[1] && match_a) begin
               wave_out_a <= ctrl.act_a[0]; // [RL13]
            end else if (ctrl.act_a == 2'h1 && ctrl.mode[2] && match_a) begin
               wave_out_a <= ~wave_out_a; // [RL14]
            end
            if (ctrl.act_b[1] && count_value == top) begin
               wave_out_b <= ~ctrl.act_b[0]; // [RL13]
            end else if (ctrl.act_b[1] && match_b) begin
               wave_out_b <= ctrl.act_b[0]; // [RL13] [RL14]
            end
         end else begin
            if (ctrl.act_a[1] && match_a) begin
               wave_out_a <= ctrl.act_a[0] ^ count_down; // [RL19]
            end else if (ctrl.act_a == 2'h1 && ctrl.mode[2] && match_a) begin
               wave_out_a <= ~wave_out_a; // [RL14]
            end
            if (ctrl.act_b[1] && match_b) begin
               wave_out_b <= ctrl.act_b[0] ^ count_down; // [RL19]
            end
         end
      end
   end

   // pin drive needs a connected channel and output direction [RL22] [RL23]
   always_comb begin
      pins.a_out = wave_out_a;
      pins.b_out = wave_out_b;
      pins.a_oe = ctrl.dir_a & (ctrl.act_a != 2'h0) &
                  ~(is_pwm & ctrl.act_a == 2'h1 & ~ctrl.mode[2]);
      pins.b_oe = ctrl.dir_b & (ctrl.act_b != 2'h0) & ~(is_pwm & ctrl.act_b == 2'h1);
   end

   assign ovf_service = overflow_flag;
   assign cmpa_pending = compare_a_flag;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_done <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (clk_en) begin
         rd_done <= avs_read & ~rd_done;
         if (avs_read && !rd_done) begin
            if (avs_address[4]) begin
               avs_readdata <= {29'h0, compare_b_flag, compare_a_flag, overflow_flag};
            end else if (sel(avs_address, ADDR_CTRL)) begin
               avs_readdata <= {22'h0, ctrl.dir_b, ctrl.dir_a, ctrl.act_b, ctrl.act_a,
                                1'b0, ctrl.mode};
            end else if (sel(avs_address, ADDR_COUNT)) begin
               avs_readdata <= {24'h0, count_value};
            end else if (sel(avs_address, ADDR_CMP_A)) begin
               avs_readdata <= {24'h0, immediate ? compare_a : buf_a};
            end else if (sel(avs_address, ADDR_CMP_B)) begin
               avs_readdata <= {24'h0, immediate ? compare_b : buf_b};
            end else begin
               avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end

   chk_normal_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && ctrl.mode == MODE_NORMAL && count_value == TMR_MAX
      |=> count_value == TMR_BOTTOM && overflow_flag) // [RL4]
      else $error("normal mode did not wrap with overflow");
   chk_ctc_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && ctrl.mode == MODE_CTC && match_a
      |=> count_value == TMR_BOTTOM) // [RL6]
      else $error("ctc did not clear on match");
   chk_ctc_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && ctrl.mode == MODE_CTC && match_a |=> compare_a_flag) // [RL8]
      else $error("compare flag not set at top");
   chk_fast_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && is_fast && count_value == top
      |=> count_value == TMR_BOTTOM && overflow_flag) // [RL12]
      else $error("fast pwm did not restart at bottom");
   chk_pc_reverse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && is_pc && count_value == top && top != TMR_BOTTOM
      |=> count_down && count_value == $past(count_value) - 8'h01) // [RL20]
      else $error("phase correct did not reverse at top");
   chk_block_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && block_next && !compare_a_flag |=> !compare_a_flag) // [RL24]
      else $error("match not blocked after count write");
   chk_pin_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !ctrl.dir_a || ctrl.act_a == 2'h0 |-> !pins.a_oe) // [RL22]
      else $error("pin driven without direction");
   chk_fast_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_ctrl && is_fast && ctrl.act_a == 2'h2 && count_value == top
      |=> wave_out_a) // [RL13]
      else $error("non-inverting output not set at bottom");
   chk_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !tick && !wr_count |=> $stable(count_value)) // [RL25]
      else $error("counter moved without enable");
   chk_normal_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && ctrl.mode == MODE_NORMAL
      |=> count_value == $past(count_value) + 8'h01) // [RL4]
      else $error("normal mode did not count up");
   chk_ctc_ovf: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && ctrl.mode == MODE_CTC && count_value == TMR_MAX
      |=> overflow_flag) // [RL10]
      else $error("ctc overflow missing at max");
   chk_ctc_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !is_pwm && match_a && ctrl.act_a == 2'h1
      |=> wave_out_a != $past(wave_out_a)) // [RL9]
      else $error("output a did not toggle on match");
   chk_pc_bottom: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && is_pc && count_down && count_value == 8'h01
      |=> count_value == TMR_BOTTOM && overflow_flag) // [RL21]
      else $error("phase correct overflow missing at bottom");
   chk_pc_turn_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !wr_count && is_pc && count_down && count_value == TMR_BOTTOM &&
      top != TMR_BOTTOM |=> !count_down && count_value == 8'h01) // [RL18]
      else $error("phase correct did not turn up at bottom");
   chk_b_no_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && is_pwm && ctrl.act_b == 2'h1 |=> $stable(wave_out_b)) // [RL14]
      else $error("output b changed with reserved action");
   chk_wave_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && ctrl.act_a == 2'h0 |=> $stable(wave_out_a)) // [RL23]
      else $error("output a changed with action 0");
   chk_fast_a_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && ctrl.mode == MODE_FAST_A && count_value == TMR_BOTTOM
      |=> compare_a == $past(buf_a)) // [RL2]
      else $error("compare not loaded at bottom");
endmodule
`default_nettype wire

// >>> sim/tmr_load.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_load
   import tmr_pkg::*;
(
   input wire tmr_pins_s pins,
   output logic pin_a,
   output logic pin_b
);
   // pads carry a pull-down, so a released pin reads low and never the last driven value
   assign pin_a = pins.a_oe ? pins.a_out : 1'h0;
   assign pin_b = pins.b_oe ? pins.b_out : 1'h0;
endmodule
`default_nettype wire

// >>> sim/timer8_waveform_modes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes_bench
   import tmr_pkg::*;
;
   typedef struct packed {
      logic [4:0] a;
      logic [3:0] be;
      logic [31:0] d;
      logic [31:0] q;
   } tmr_row_s;

   logic sys_clk;
   logic rst_n = 1'h0;
   logic clk_en = 1'h1;
   logic count_en = 1'h0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic ovf_ack = 1'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic ovf_service;
   logic cmpa_pending;
   tmr_pins_s pins;
   logic pin_a;
   logic pin_b;
   logic [31:0] rd;
   int err_total = 0;
   int num_checks = 0;

   // unmapped offset, a write without lane 0 and the flag register ride along with the rest
   tmr_row_s rows [8] = '{
      '{5'h00, 4'hf, 32'hffff_ffff, 32'h0000_03f7},
      '{5'h00, 4'he, 32'h0000_0000, 32'h0000_03f7},
      '{5'h00, 4'hf, 32'h0000_0000, 32'h0000_0000},
      '{5'h04, 4'hf, 32'h0000_01ab, 32'h0000_00ab},
      '{5'h08, 4'hf, 32'h0000_01cd, 32'h0000_00cd},
      '{5'h0c, 4'hf, 32'h0000_000e, 32'h0000_000e},
      '{5'h02, 4'hf, 32'h0000_00ff, 32'h0000_0000},
      '{5'h10, 4'hf, 32'h0000_0007, 32'h0000_0000}};
   logic [9:0] oe_ctl [4] = '{10'h100, 10'h020, 10'h120, 10'h280};
   logic [1:0] oe_exp [4] = '{2'h0, 2'h0, 2'h2, 2'h1};

   tmr_core u_dut (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .count_en(count_en),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .ovf_service(ovf_service),
      .ovf_ack(ovf_ack),
      .cmpa_pending(cmpa_pending),
      .pins(pins)
   );

   tmr_load u_load (
      .pins(pins),
      .pin_a(pin_a),
      .pin_b(pin_b)
   );

   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // the request stands until the rising edge that sees waitrequest low; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
         input logic [3:0] be);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hf);
   endtask

   task automatic rd_reg(input logic [4:0] a);
      bus(1'h0, a, 32'h0, 4'hf);
      @(negedge sys_clk);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         count_en <= 1'h1;
         @(posedge sys_clk);
         count_en <= 1'h0;
      end
   endtask

   task automatic ack_ovf();
      @(posedge sys_clk);
      ovf_ack <= 1'h1;
      @(posedge sys_clk);
      ovf_ack <= 1'h0;
      @(negedge sys_clk);
   endtask

   task automatic wrap_up();
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(negedge sys_clk);
      check("pins after reset", {28'h0, pins}, 32'h0);
      foreach (rows[i]) begin
         bus(1'h1, rows[i].a, rows[i].d, rows[i].be);
         rd_reg(rows[i].a);
         check("register readback", rd, rows[i].q);
      end
      foreach (oe_ctl[i]) begin
         wr(5'h00, {22'h0, oe_ctl[i]});
         @(negedge sys_clk);
         check("pin enables", {30'h0, pins.a_oe, pins.b_oe}, {30'h0, oe_exp[i]});
         check("pin b level", {31'h0, pin_b}, 32'h0);
      end
      // clear-on-compare, count written equal to TOP so the first match is blocked
      wr(5'h08, 32'h3);
      wr(5'h00, 32'h112);
      wr(5'h04, 32'h3);
      tick(1);
      rd_reg(5'h04);
      check("count after blocked match", rd, 32'h4);
      check("wave a after blocked match", {31'h0, pin_a}, 32'h0);
      tick(252);
      rd_reg(5'h04);
      check("count after wrap", rd, 32'h0);
      check("overflow at wrap", {31'h0, ovf_service}, 32'h1);
      check("compare flag before top", {31'h0, cmpa_pending}, 32'h0);
      tick(4);
      rd_reg(5'h04);
      check("count cleared at top", rd, 32'h0);
      check("wave a toggled", {31'h0, pin_a}, 32'h1);
      check("compare flag at top", {31'h0, cmpa_pending}, 32'h1);
      wr(5'h10, 32'h2);
      ack_ovf();
      check("flags cleared", {30'h0, ovf_service, cmpa_pending}, 32'h0);
      // normal mode wrap
      wr(5'h00, 32'h0);
      wr(5'h04, 32'hfd);
      tick(2);
      rd_reg(5'h04);
      check("normal count", rd, 32'hff);
      check("no overflow at max", {31'h0, ovf_service}, 32'h0);
      tick(1);
      rd_reg(5'h04);
      check("normal wrap", rd, 32'h0);
      check("overflow at zero", {31'h0, ovf_service}, 32'h1);
      ack_ovf();
      check("overflow serviced", {31'h0, ovf_service}, 32'h0);
      // fast pwm, inverting; compare written mid-period must wait for TOP
      wr(5'h08, 32'h10);
      wr(5'h00, 32'h133);
      wr(5'h04, 32'hfe);
      tick(1);
      rd_reg(5'h04);
      check("fast top", rd, 32'hff);
      tick(1);
      @(negedge sys_clk);
      check("cleared at bottom", {31'h0, pin_a}, 32'h0);
      check("overflow at top", {31'h0, ovf_service}, 32'h1);
      ack_ovf();
      tick(8);
      wr(5'h08, 32'h40);
      rd_reg(5'h08);
      check("compare buffer", rd, 32'h40);
      tick(9);
      rd_reg(5'h04);
      check("fast count", rd, 32'h11);
      check("set on old compare", {31'h0, pin_a}, 32'h1);
      // phase correct, turn at TOP and overflow only at BOTTOM
      wr(5'h00, 32'h1);
      wr(5'h04, 32'hfe);
      tick(1);
      rd_reg(5'h04);
      check("pc top", rd, 32'hff);
      tick(1);
      rd_reg(5'h04);
      check("pc reversed", rd, 32'hfe);
      check("no overflow at top", {31'h0, ovf_service}, 32'h0);
      tick(254);
      rd_reg(5'h04);
      check("pc bottom", rd, 32'h0);
      check("overflow at bottom", {31'h0, ovf_service}, 32'h1);
      // reset in mid-run: one edge low, first request on the edge after release
      @(posedge sys_clk);
      rst_n <= 1'h0;
      @(posedge sys_clk);
      rst_n <= 1'h1;
      @(negedge sys_clk);
      check("overflow after reset", {31'h0, ovf_service}, 32'h0);
      rd_reg(5'h00);
      check("mode after reset", rd, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
